// >>> dssa_core.sv
// debug-state control: speed select, system access, coprocessor chain, exit
//
// Summary of operation
// - flag low runs at debug speed; flag high on prior word gives system speed
// - after system instruction loads and bypass selected, run on memory clock
// - on completion acknowledge is high and debug clock selected again
// - after resync drive memory request low; arbiter may stall indefinitely
// - returning from system access sets flag bit high in chain
// - coprocessor data operation uses one extra idle tck cycle
// - after resume wait for run-test/idle then resync and fetch
// - breakpoint entry adds 16 bytes; each debug instruction adds 4
// - chain shifts msb first: flag then 32-bit word
// - watchpoint increments match breakpoint; return targets next instruction
// - watchpoint with exception delays entry until vector fetched
// - watchpoint with exception adds three words on entry
// - debug request adds three words on entry and one per instruction
// - in normal operation run from memory clock, debug clock held low
// - coprocessor chain is 33 bits, flag 1 instruction, 0 data
`timescale 1ns/10ps
`include "dssa_regs.svh"
module dssa_core #(
    parameter int CHAIN_LEN = `DSSA_CHAIN_LEN
) (
    input  wire logic                  clk_sys,
    input  wire logic                  nrst,
    input  wire logic                  clk_tck,
    input  wire logic                  tck_nrst,
    input  wire logic                  shift_dr,
    input  wire logic                  update_dr,
    input  wire logic                  capture_dr,
    input  wire logic                  run_idle,
    input  wire logic                  tdi,
    input  wire dssa_pkg::dssa_tapins_t tap_ins,
    input  wire logic                  sel_coproc,
    output logic                       tdo,
    input  wire logic                  debug_entry,
    input  wire logic [1:0]            entry_src,
    input  wire logic                  exc_pending,
    input  wire logic                  vector_fetched,
    input  wire logic                  bus_grant,
    input  wire logic                  access_done,
    output logic                       debug_acknowledge,
    output logic                       memory_request_n,
    output logic                       debug_core_clock,
    output logic                       use_debug_clock,
    output logic                       exec_strobe,
    output dssa_pkg::dssa_entry_t      exec_entry,
    output logic                       coproc_strobe,
    output dssa_pkg::dssa_entry_t      coproc_entry,
    output logic [`DSSA_PC_W-1:0]      pc_offset,
    output dssa_pkg::dssa_status_t     status
);
    // ------------------------------------------------------------
    // system-domain state machine
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_RUN, ST_HOLD, ST_DEBUG, ST_SYNC, ST_REQ, ST_ACCESS, ST_EXIT
    } dssa_state_t;
    dssa_state_t state_ff;
    dssa_state_t nxt_state;
    // tck domain registers
    logic [CHAIN_LEN-1:0] shreg_ff;
    logic                 sys_pending_ff;
    logic                 arm_sys_ff;
    logic                 run_tgl_ff;
    logic                 exit_tgl_ff;
    logic                 resume_seen_ff;
    logic                 idle_cnt_ff;
    logic                 exit_pend;
    // sys domain to tck crossings
    logic [1:0]           ack_sync_ff;
    logic [1:0]           mreq_sync_ff;
    logic                 ret_tgl_ff;
    logic [1:0]           ret_sync_ff;
    logic                 ret_seen_ff;
    // tck to sys crossings and pin synchronisers
    logic [2:0]           run_sync_ff;
    logic [2:0]           exit_sync_ff;
    logic [1:0]           entry_sync_ff;
    logic [1:0]           exc_sync_ff;
    logic [1:0]           vec_sync_ff;
    logic [1:0]           src_sync0_ff;
    logic [1:0]           src_sync1_ff;
    logic [1:0]           grant_sync_ff;
    logic [1:0]           done_sync_ff;
    logic [`DSSA_PC_W-1:0] pc_ff;
    logic                 exec_tgl_ff;
    logic [2:0]           exec_sync_ff;

    // ------------------------------------------------------------
    // tck domain: chain shift, update and exit tracking
    // ------------------------------------------------------------
    wire ret_event    = ret_sync_ff[1] != ret_seen_ff;
    wire ack_tck      = ack_sync_ff[1];
    wire chain_flag   = shreg_ff[CHAIN_LEN-1];
    wire exec_load    = update_dr && !sel_coproc && tap_ins == dssa_pkg::DSSA_TAP_INTEST;
    wire cop_load     = update_dr && sel_coproc && tap_ins == dssa_pkg::DSSA_TAP_INTEST;
    wire resume_go    = resume_seen_ff && run_idle;
    wire [CHAIN_LEN-1:0] cap_word = {1'b1, shreg_ff[CHAIN_LEN-2:0]};

    always_ff @(posedge clk_tck) begin
        if (!tck_nrst) begin
            shreg_ff <= '0;
        end else if (capture_dr && ret_event) begin
            shreg_ff <= cap_word;
        end else if (shift_dr) begin
            shreg_ff <= {shreg_ff[CHAIN_LEN-2:0], tdi};
        end
    end

    always_ff @(posedge clk_tck) begin
        if (!tck_nrst) begin
            ret_seen_ff <= 1'b0;
            ack_sync_ff <= '0;
            mreq_sync_ff <= 2'b11;
            ret_sync_ff <= '0;
        end else begin
            ack_sync_ff <= {ack_sync_ff[0], debug_acknowledge};
            mreq_sync_ff <= {mreq_sync_ff[0], memory_request_n};
            ret_sync_ff <= {ret_sync_ff[0], ret_tgl_ff};
            if (capture_dr && ret_event) begin
                ret_seen_ff <= ret_sync_ff[1];
            end
        end
    end

    always_ff @(posedge clk_tck) begin
        if (!tck_nrst) begin
            arm_sys_ff <= 1'b0;
            sys_pending_ff <= 1'b0;
            run_tgl_ff <= 1'b0;
            exec_tgl_ff <= 1'b0;
        end else begin
            if (exec_load) begin
                // a word after a flagged one runs at system speed, not here
                if (!arm_sys_ff) begin
                    exec_tgl_ff <= ~exec_tgl_ff;
                end
                arm_sys_ff <= chain_flag;
                sys_pending_ff <= arm_sys_ff;
            end
            if (sys_pending_ff && tap_ins == dssa_pkg::DSSA_TAP_BYPASS && ack_tck
                && !exit_pend) begin
                run_tgl_ff <= ~run_tgl_ff;
                sys_pending_ff <= 1'b0;
            end
        end
    end

    // exit happens when resume was selected while acknowledged and run-test/idle follows
    always_ff @(posedge clk_tck) begin
        if (!tck_nrst) begin
            resume_seen_ff <= 1'b0;
            exit_tgl_ff <= 1'b0;
        end else begin
            // forget a stale resume once out of debug, so re-entry cannot fire it
            if (!ack_tck) begin
                resume_seen_ff <= 1'b0;
            end else if (tap_ins == dssa_pkg::DSSA_TAP_RESUME) begin
                resume_seen_ff <= 1'b1;
            end
            if (resume_go) begin
                exit_tgl_ff <= ~exit_tgl_ff;
                resume_seen_ff <= 1'b0;
            end
        end
    end
    assign exit_pend = resume_seen_ff;

    // coprocessor chain: extra idle tck performs the data operation
    always_ff @(posedge clk_tck) begin
        if (!tck_nrst) begin
            idle_cnt_ff <= 1'b0;
            coproc_strobe <= 1'b0;
            coproc_entry <= '0;
            exec_entry <= '0;
            tdo <= 1'b0;
        end else begin
            tdo <= shreg_ff[CHAIN_LEN-1];
            coproc_strobe <= 1'b0;
            if (cop_load) begin
                coproc_entry <= shreg_ff;
                idle_cnt_ff <= !shreg_ff[CHAIN_LEN-1];
            end else if (idle_cnt_ff && run_idle) begin
                coproc_strobe <= 1'b1;
                idle_cnt_ff <= 1'b0;
            end
            if (exec_load) begin
                exec_entry <= shreg_ff;
            end
        end
    end

    // ------------------------------------------------------------
    // system domain
    // ------------------------------------------------------------
    wire run_event   = run_sync_ff[2] != run_sync_ff[1];
    wire exit_event  = exit_sync_ff[2] != exit_sync_ff[1];
    wire exec_event  = exec_sync_ff[2] != exec_sync_ff[1];
    wire entry_ok    = entry_sync_ff[1] && (!exc_sync_ff[1] || vec_sync_ff[1]);

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            run_sync_ff <= '0;
            exit_sync_ff <= '0;
            exec_sync_ff <= '0;
        end else begin
            run_sync_ff <= {run_sync_ff[1:0], run_tgl_ff};
            exit_sync_ff <= {exit_sync_ff[1:0], exit_tgl_ff};
            exec_sync_ff <= {exec_sync_ff[1:0], exec_tgl_ff};
        end
    end

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            entry_sync_ff <= '0;
            exc_sync_ff <= '0;
            vec_sync_ff <= '0;
            src_sync0_ff <= '0;
            src_sync1_ff <= '0;
            grant_sync_ff <= '0;
            done_sync_ff <= '0;
        end else begin
            entry_sync_ff <= {entry_sync_ff[0], debug_entry};
            exc_sync_ff <= {exc_sync_ff[0], exc_pending};
            vec_sync_ff <= {vec_sync_ff[0], vector_fetched};
            src_sync0_ff <= entry_src;
            src_sync1_ff <= src_sync0_ff;
            grant_sync_ff <= {grant_sync_ff[0], bus_grant};
            done_sync_ff <= {done_sync_ff[0], access_done};
        end
    end

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_RUN:    if (entry_sync_ff[1]) nxt_state = ST_HOLD;
            ST_HOLD:   if (entry_ok) nxt_state = ST_DEBUG;
            ST_DEBUG:  if (exit_event) nxt_state = ST_EXIT;
                       else if (run_event) nxt_state = ST_SYNC;
            ST_SYNC:   nxt_state = ST_REQ;
            ST_REQ:    if (grant_sync_ff[1]) nxt_state = ST_ACCESS;
            ST_ACCESS: if (done_sync_ff[1]) nxt_state = ST_DEBUG;
            ST_EXIT:   nxt_state = ST_RUN;
        endcase
    end

    wire sys_return  = state_ff == ST_ACCESS && done_sync_ff[1];
    wire enter_debug = state_ff == ST_HOLD && entry_ok;
    wire exc_entry   = src_sync1_ff == `DSSA_SRC_REQ || exc_sync_ff[1];
    // watchpoint without exception shares the breakpoint entry step
    wire [`DSSA_PC_W-1:0] entry_add = exc_entry ? `DSSA_PC_EXC_ENTRY
                                                : `DSSA_PC_BKPT_ENTRY;

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            state_ff <= ST_RUN;
            ret_tgl_ff <= 1'b0;
            pc_ff <= '0;
            exec_strobe <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            exec_strobe <= exec_event && state_ff == ST_DEBUG;
            if (sys_return) begin
                ret_tgl_ff <= ~ret_tgl_ff;
            end
            if (enter_debug) begin
                pc_ff <= entry_add;
            end else if (exec_event && state_ff == ST_DEBUG) begin
                pc_ff <= pc_ff + `DSSA_PC_STEP;
            end
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    wire in_debug  = state_ff == ST_DEBUG;
    wire in_req    = state_ff == ST_REQ;
    wire in_access = state_ff == ST_ACCESS;
    // acknowledge stays low while entry is held off
    assign debug_acknowledge = in_debug;
    assign memory_request_n  = !(in_req || in_access);
    assign use_debug_clock   = in_debug;
    assign debug_core_clock  = in_debug ? clk_tck : 1'b0;
    assign pc_offset         = pc_ff;
    assign status            = '{debug_acknowledge: ack_sync_ff[1],
                                 memory_request_n: mreq_sync_ff[1]};
endmodule // dssa_core

// >>> dssa_core_asserts.sv
// assertions for the debug-state block
`timescale 1ns/10ps
`include "dssa_regs.svh"
module dssa_core_asserts #(
    parameter int CHAIN_LEN = 33
) (
    input wire logic                   clk_sys,
    input wire logic                   nrst,
    input wire logic                   clk_tck,
    input wire logic                   tck_nrst,
    input wire logic                   run_idle,
    input wire dssa_pkg::dssa_tapins_t tap_ins,
    input wire logic                   sel_coproc,
    input wire logic                   debug_entry,
    input wire logic [1:0]             entry_src,
    input wire logic                   exc_pending,
    input wire logic                   vector_fetched,
    input wire logic                   access_done,
    input wire logic                   debug_acknowledge,
    input wire logic                   memory_request_n,
    input wire logic                   debug_core_clock,
    input wire logic                   exec_strobe,
    input wire logic                   coproc_strobe,
    input wire dssa_pkg::dssa_status_t status
);
    sequence out_of_debug;
        !debug_acknowledge [*3];
    endsequence
    sequence back_in_debug;
        debug_acknowledge && memory_request_n;
    endsequence
    exec_in_debug_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        exec_strobe |-> back_in_debug) else $error("strobe outside debug");
    ack_fall_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        $fell(debug_acknowledge) |-> tap_ins inside {dssa_pkg::DSSA_TAP_BYPASS,
        dssa_pkg::DSSA_TAP_RESUME}) else $error("debug left without bypass or resume");
    access_end_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        access_done && !memory_request_n |-> ##[1:12] back_in_debug) else $error("no return");
    req_no_ack_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        !memory_request_n |-> !debug_acknowledge) else $error("request while acknowledged");
    resume_run_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        debug_acknowledge && run_idle && tap_ins == dssa_pkg::DSSA_TAP_RESUME
        |-> ##[1:16] !debug_acknowledge) else $error("resume not taken");
    entry_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        debug_entry && entry_src == `DSSA_SRC_WATCH && exc_pending && !vector_fetched
        && !debug_acknowledge |=> !debug_acknowledge) else $error("entry before vector");
    debug_core_clock_idle_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        out_of_debug |-> !debug_core_clock) else $error("debug clock runs outside debug");
    coproc_idle_a: assert property (@(posedge clk_tck) disable iff (!tck_nrst)
        coproc_strobe |-> sel_coproc && ($past(run_idle) || $past(run_idle, 2)))
        else $error("coprocessor strobe without idle");
    status_ack_a: assert property (@(posedge clk_tck) disable iff (!tck_nrst)
        debug_acknowledge [*5] |-> status.debug_acknowledge) else $error("status ack stale");
    status_req_a: assert property (@(posedge clk_tck) disable iff (!tck_nrst)
        memory_request_n [*5] |-> status.memory_request_n) else $error("status request stale");
endmodule // dssa_core_asserts
bind dssa_core dssa_core_asserts #(.CHAIN_LEN(CHAIN_LEN)) dssa_core_asserts_i (.clk_sys, .nrst,
    .clk_tck, .tck_nrst, .run_idle, .tap_ins, .sel_coproc, .debug_entry, .entry_src,
    .exc_pending, .vector_fetched, .access_done, .debug_acknowledge, .memory_request_n,
    .debug_core_clock, .exec_strobe, .coproc_strobe, .status);

// >>> dssa_host_model.sv
// debugger and memory arbiter model for the debug-state block
`timescale 1ns/10ps
module dssa_host_model (
    input  wire logic             clk_tck,
    input  wire logic             clk_sys,
    input  wire logic             memory_request_n,
    input  wire logic [3:0]       stall,
    input  wire logic             tdo,
    output logic                  shift_dr,
    output logic                  update_dr,
    output logic                  capture_dr,
    output logic                  run_idle,
    output logic                  tdi,
    output dssa_pkg::dssa_tapins_t tap_ins,
    output logic                  sel_coproc,
    output logic                  bus_grant,
    output logic                  access_done,
    output logic                  first_bit
);
    logic [3:0] wait_ff;
    initial begin
        {shift_dr, update_dr, capture_dr, run_idle, tdi, sel_coproc} = '0;
        {bus_grant, access_done, wait_ff} = '0;
        tap_ins = dssa_pkg::DSSA_TAP_OTHER;
        first_bit = 1'h0;
    end
    // ----------------------------------------------------------------
    // arbiter: grant after a chosen stall, done once granted
    // ----------------------------------------------------------------
    always @(posedge clk_sys) begin
        wait_ff <= memory_request_n ? 4'h0 : wait_ff + 4'h1;
        bus_grant <= !memory_request_n && (bus_grant || wait_ff >= stall);
        access_done <= bus_grant && !memory_request_n;
    end
    task automatic set_ins(input dssa_pkg::dssa_tapins_t ins, input logic sel);
        @(posedge clk_tck);
        tap_ins <= ins;
        sel_coproc <= sel;
    endtask
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge clk_tck);
            run_idle <= 1'h1;
        end
        @(posedge clk_tck);
        run_idle <= 1'h0;
    endtask
    // capture, then flag first and the word msb first, then update
    // the captured flag leaves on tdo after the first shift edge
    task automatic scan(input dssa_pkg::dssa_entry_t e);
        @(posedge clk_tck);
        capture_dr <= 1'h1;
        for (int i = 32; i >= 0; i--) begin
            @(posedge clk_tck);
            capture_dr <= 1'h0;
            shift_dr <= 1'h1;
            tdi <= e[i];
            if (i == 31) begin
                @(negedge clk_tck);
                first_bit = tdo;
            end
        end
        @(posedge clk_tck);
        shift_dr <= 1'h0;
        tdi <= ~tdi;
        update_dr <= 1'h1;
        @(posedge clk_tck);
        update_dr <= 1'h0;
    endtask
endmodule // dssa_host_model

// >>> dssa_pkg.sv
// types for the debug-state system access block
package dssa_pkg;
    typedef enum logic [1:0] {
        DSSA_TAP_OTHER,
        DSSA_TAP_BYPASS,
        DSSA_TAP_INTEST,
        DSSA_TAP_RESUME
    } dssa_tapins_t;
    typedef struct packed {
        logic        speed_select_flag;
        logic [31:0] word;
    } dssa_entry_t;
    typedef struct packed {
        logic debug_acknowledge;
        logic memory_request_n;
    } dssa_status_t;
endpackage

// >>> dssa_regs.svh
// constants for the debug-state system access block
`ifndef DSSA_REGS_SVH
`define DSSA_REGS_SVH
`define DSSA_CHAIN_LEN       33
`define DSSA_FLAG_BIT        32
`define DSSA_PC_W            32
`define DSSA_PC_BKPT_ENTRY   32'h0000_0010
`define DSSA_PC_EXC_ENTRY    32'h0000_000C
`define DSSA_PC_STEP         32'h0000_0004
`define DSSA_SRC_BKPT        2'h0
`define DSSA_SRC_WATCH       2'h1
`define DSSA_SRC_REQ         2'h2
`endif

// >>> tb_dssa_core.sv
// self-checking bench for the debug-state block
`timescale 1ns/10ps
`include "dssa_regs.svh"
module tb_dssa_core;
    logic clk_sys, clk_tck, nrst, tck_nrst, debug_entry, exc_pending, vector_fetched;
    logic shift_dr, update_dr, capture_dr, run_idle, tdi, sel_coproc, bus_grant, access_done;
    logic debug_acknowledge, memory_request_n, debug_core_clock, exec_strobe, coproc_strobe;
    logic tdo, first_bit, use_debug_clock;
    logic [1:0]             entry_src;
    logic [3:0]             stall;
    logic [31:0]            pc_offset, pc_exp;
    dssa_pkg::dssa_tapins_t tap_ins;
    dssa_pkg::dssa_entry_t  exec_entry, coproc_entry, w, exp_q[$], cp_q[$];
    dssa_pkg::dssa_status_t status;
    wire  [3:0]             clk_pins = {debug_acknowledge, memory_request_n,
                                        debug_core_clock, use_debug_clock};
    int                     mismatches = 0, cmp_count = 0, cycles = 0;
    initial begin
        clk_sys = 1'h0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    initial begin
        clk_tck = 1'h0;
        #7;
        forever #40 clk_tck = ~clk_tck;
    end
    dssa_core dssa_core_i (.clk_sys, .nrst, .clk_tck, .tck_nrst, .shift_dr, .update_dr,
        .capture_dr, .run_idle, .tdi, .tap_ins, .sel_coproc, .tdo, .debug_entry, .entry_src,
        .exc_pending, .vector_fetched, .bus_grant, .access_done, .debug_acknowledge,
        .memory_request_n, .debug_core_clock, .use_debug_clock, .exec_strobe, .exec_entry,
        .coproc_strobe, .coproc_entry, .pc_offset, .status);
    dssa_host_model dssa_host_model_i (.clk_tck, .clk_sys, .memory_request_n, .stall, .tdo,
        .shift_dr, .update_dr, .capture_dr, .run_idle, .tdi, .tap_ins, .sel_coproc,
        .bus_grant, .access_done, .first_bit);
    task automatic cmp_entry(input dssa_pkg::dssa_entry_t e, input dssa_pkg::dssa_entry_t g);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected entry at %0t: %h not %h", $time, g, e);
        end
    endtask
    task automatic cmp_word(input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected value at %0t: %h not %h", $time, g, e);
        end
    endtask
    task automatic end_of_test;
        $display("mismatches %0d, comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            end_of_test();
        end
    end
    always @(posedge clk_sys) if (exec_strobe === 1'h1)
        cmp_entry(exp_q.size() > 0 ? exp_q.pop_front() : 'x, exec_entry);
    always @(posedge clk_tck) if (coproc_strobe === 1'h1)
        cmp_entry(cp_q.size() > 0 ? cp_q.pop_front() : 'x, coproc_entry);
    task automatic dbg(input logic f, input logic [31:0] d, input logic ex);
        if (ex) exp_q.push_back({f, d});
        if (ex) pc_exp += `DSSA_PC_STEP;
        dssa_host_model_i.scan({f, d});
    endtask
    task automatic settle;
        repeat (10) @(posedge clk_sys);
    endtask
    initial begin
        void'($urandom(32'h777e_75ca));
        {nrst, tck_nrst, debug_entry, exc_pending, vector_fetched, entry_src, stall} = '0;
        pc_exp = '0;
        repeat (5) @(posedge clk_sys);
        nrst <= 1'h1;
        repeat (5) @(posedge clk_tck);
        tck_nrst <= 1'h1;
        repeat (4) @(posedge clk_tck);
        @(posedge clk_sys);
        cmp_word(32'h0000_0004, {28'h0, clk_pins});
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_sys);
            entry_src <= (i == 3) ? `DSSA_SRC_WATCH : 2'(i);
            exc_pending <= (i == 3);
            vector_fetched <= (i != 3);
            debug_entry <= 1'h1;
            pc_exp = (i < 2) ? `DSSA_PC_BKPT_ENTRY : `DSSA_PC_EXC_ENTRY;
            settle;
            if (i == 3) cmp_word(32'h0, {31'h0, debug_acknowledge});
            vector_fetched <= 1'h1;
            while (debug_acknowledge !== 1'h1) @(posedge clk_sys);
            debug_entry <= 1'h0;
            exc_pending <= 1'h0;
            settle;
            cmp_word(pc_exp, pc_offset);
            dssa_host_model_i.set_ins(dssa_pkg::DSSA_TAP_INTEST, 1'h0);
            dbg(1'h0, $urandom, 1'h1);
            dbg(1'h0, $urandom, 1'h1);
            settle;
            cmp_word(pc_exp, pc_offset);
            cmp_word(32'h0000_0003, {30'h0, status});
            dssa_host_model_i.set_ins(dssa_pkg::DSSA_TAP_INTEST, 1'h1);
            dbg(1'h1, $urandom, 1'h0);
            w = {1'h0, $urandom};
            cp_q.push_back(w);
            dssa_host_model_i.scan(w);
            dssa_host_model_i.idle(2);
            dssa_host_model_i.set_ins(dssa_pkg::DSSA_TAP_INTEST, 1'h0);
            stall <= 4'($urandom_range(6));
            dbg(1'h1, $urandom, 1'h1);
            dbg(1'h0, $urandom, 1'h0);
            dssa_host_model_i.set_ins(dssa_pkg::DSSA_TAP_BYPASS, 1'h0);
            while (memory_request_n !== 1'h0) @(posedge clk_sys);
            while ({debug_acknowledge, memory_request_n} !== 2'h3) @(posedge clk_sys);
            dssa_host_model_i.set_ins(dssa_pkg::DSSA_TAP_INTEST, 1'h0);
            dbg(1'h1, $urandom, 1'h1);
            cmp_word(32'h0000_0001, {31'h0, first_bit});
            dbg(1'h0, $urandom, 1'h0);
            dssa_host_model_i.set_ins(dssa_pkg::DSSA_TAP_RESUME, 1'h0);
            settle;
            cmp_word(32'h0000_0001, {31'h0, debug_acknowledge});
            dssa_host_model_i.idle(1);
            while (debug_acknowledge !== 1'h0) @(posedge clk_sys);
            dssa_host_model_i.set_ins(dssa_pkg::DSSA_TAP_OTHER, 1'h0);
            settle;
            cmp_word(32'h0000_0004, {28'h0, clk_pins});
            cmp_word(32'h0, 32'(exp_q.size() + cp_q.size()));
        end
        end_of_test();
    end
endmodule // tb_dssa_core
